/* File: logic/hpp_pkg.sv */
/*
 * Shared constants and types for the host processor bus port.
 * Assumes a single 50 MHz clock and an APB master for its registers.
 */
package hpp_pkg;
   // Data path geometry
   localparam int HPP_DW = 32;
   localparam int HPP_AW = 18;
   localparam int HPP_LANES = 4;
   localparam int HPP_FIFO_DEPTH = 16;
   // Beats after the first in one burst, counter reload value
   localparam logic [1:0] HPP_BURST_LAST = 2'h3;
   // Strap decode: mode[3:2] selects host port mode, mode[1:0] the width
   localparam logic [1:0] HPP_MODE_HOST = 2'h2;
   localparam logic [1:0] HPP_W8 = 2'h0;
   localparam logic [1:0] HPP_W16 = 2'h1;
   localparam logic [1:0] HPP_W32 = 2'h2;
   // Address regions, top two address bits
   localparam logic [1:0] HPP_REGION_CFG = 2'h0;
   localparam logic [1:0] HPP_REGION_USER = 2'h1;
   localparam logic [1:0] HPP_REGION_FAB = 2'h2;
   // Parity sense: 0 gives even parity per byte lane
   localparam logic HPP_PAR_ODD = 1'h0;
   // APB register offsets
   localparam logic [7:0] HPP_REG_CTRL = 8'h00;
   localparam logic [7:0] HPP_REG_STAT = 8'h04;
   localparam logic [7:0] HPP_REG_COUNT = 8'h08;
   // Control fields and reset value
   localparam int HPP_CTRL_KEEP_BIT = 0;
   localparam int HPP_CTRL_WIDTH_LSB = 1;
   localparam logic [2:0] HPP_CTRL_RST = 3'h4;
   // Status fields
   localparam int HPP_STAT_AVAIL_BIT = 0;
   localparam int HPP_STAT_HOST_BIT = 1;
   localparam int HPP_STAT_PERR_BIT = 2;
   localparam int HPP_STAT_WIDTH_LSB = 4;
   localparam int HPP_STAT_STATE_LSB = 8;
   // Transaction engine states
   typedef enum logic [1:0] {
      HPP_IDLE = 2'b00,
      HPP_SBUS = 2'b01,
      HPP_FIFO = 2'b10,
      HPP_ACK = 2'b11
   } hpp_state_t;
endpackage

/* File: logic/hpp_port.sv */
/*
 * Host processor bus port: FIFO toward the fabric and the port top.
 * Assumes host pins arrive asynchronously, the system bus runs on
 * clk_sys, and a pad ring resolves the enables into wires.
 */
`timescale 1ns/1ps

// Flip-flop FIFO, honest full and empty
module hpp_fifo import hpp_pkg::*; #(
   parameter int W = 32,
   parameter int D = 16
) (
   // Clock and control
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic clk_en,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = $clog2(D);
   logic [W-1:0] mem [D];   // Storage words
   logic [PW-1:0] wr_ptr;   // Next slot to fill
   logic [PW-1:0] rd_ptr;   // Oldest word
   logic [PW:0] count;      // Words held
   logic push;
   logic pop;

   // Room left while fewer than D words are held
   assign in_ready = (count < (PW+1)'(D));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage write
   always_ff @(posedge clk_sys) begin
      if (clk_en && push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else if (clk_en) begin
         if (push) begin
            wr_ptr <= (wr_ptr == PW'(D - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PW'(D - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule // hpp_fifo

// Function
// RULE1 - 8, 16, 32 bit data with lane parity
// RULE2 - Control works after reset in host mode
// RULE3 - Width taken from mode straps during configuration
// RULE4 - Port kept only if instantiated or enabled
// RULE5 - Parity enable comes from configuration data
// RULE6 - Unused port pads serve user I/O; the code hands over only the data pads and keeps ta_n driven
// RULE7 - Separate domain possible, synchronise crossings safely
// RULE8 - Pipelined accesses without extra bus cycles
// RULE9 - Host announces bursts in advance
// RULE10 - Direct fabric data path for block transfers
// RULE11 - Carries configuration and user data accesses
// RULE12 - Bridges host transactions onto system bus
// RULE13 - Address captured on edge after strobe
// RULE14 - Host drives eighteen low address bits
// RULE15 - One even parity bit per byte lane
module hpp_port import hpp_pkg::*; (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic clk_en,
   // Straps and configuration status
   input wire logic [3:0] cfg_mode,
   input wire logic config_done,
   input wire logic port_inst,
   input wire logic par_en_cfg,
   // Host pins
   input wire logic transaction_strobe_n,
   input wire logic host_rw,
   input wire logic burst_n,
   input wire logic [HPP_AW-1:0] host_address_bus,
   input wire logic [HPP_DW-1:0] hd_in,
   output logic [HPP_DW-1:0] hd_out,
   output logic hd_oe_n,
   input wire logic [HPP_LANES-1:0] hp_in,
   output logic [HPP_LANES-1:0] hp_out,
   output logic hp_oe_n,
   output logic ta_n,
   // User logic sharing the data pads
   input wire logic [HPP_DW-1:0] user_d_out,
   input wire logic user_d_oe_n,
   output logic pads_user,
   // System bus master
   output logic sb_req,
   output logic sb_we,
   output logic sb_cfg,
   output logic [HPP_AW-1:0] sb_addr,
   output logic [HPP_DW-1:0] sb_wdata,
   input wire logic [HPP_DW-1:0] sb_rdata,
   input wire logic sb_ack,
   // Fabric stream
   output logic fab_valid,
   input wire logic fab_ready,
   output logic [HPP_DW-1:0] fab_data,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   localparam int SW = 4 + HPP_AW + HPP_DW + HPP_LANES + 4;

   logic [SW-1:0] sync1;          // First stage, read only by sync2
   logic [SW-1:0] sync2;          // Settled pin values
   logic strb_s;                  // Strobe, active high after sync
   logic rw_s;
   logic burst_s;
   logic [HPP_AW-1:0] addr_s;
   logic [HPP_DW-1:0] data_s;
   logic [HPP_LANES-1:0] par_s;
   logic [3:0] mode_s;
   logic mode_taken;              // Straps latched after release
   logic host_mode;
   logic [1:0] strap_width;
   logic [2:0] ctrl;              // Keep bit and post-config width
   logic par_err;                 // Sticky parity fault
   logic [15:0] xfer_count;       // Completed beats
   hpp_state_t state;
   hpp_state_t next_state;
   logic [HPP_AW-1:0] cur_addr;
   logic cur_rd;
   logic [1:0] beats_left;
   logic in_burst;
   logic [HPP_DW-1:0] rd_data;
   logic avail;
   logic [1:0] width;
   logic [HPP_LANES-1:0] lanes;
   logic [HPP_DW-1:0] lane_bits;
   logic [HPP_LANES-1:0] par_gen;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic apb_wr;
   logic apb_rd_ok;
   logic start;
   logic strb_prev;               // Settled strobe one cycle ago
   logic perr_now;
   logic ack_done;

   // RULE7 pin sync: every host input crosses two flops
   // No reset here, so the straps are already settled when reset lifts
   always_ff @(posedge clk_sys) begin
      if (clk_en) begin
         sync1 <= {cfg_mode, ~transaction_strobe_n, host_rw, ~burst_n, 1'b0,
                   host_address_bus, hd_in, hp_in};
         sync2 <= sync1;
      end
   end

   // RULE13 strobe edge: a strobe held until the answer is taken once
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         strb_prev <= 1'b0;
      end else if (clk_en) begin
         strb_prev <= strb_s;
      end
   end
   assign {mode_s, strb_s, rw_s, burst_s} = sync2[SW-1:SW-7];
   assign addr_s = sync2[HPP_AW+HPP_DW+HPP_LANES-1:HPP_DW+HPP_LANES];
   assign data_s = sync2[HPP_DW+HPP_LANES-1:HPP_LANES];
   assign par_s = sync2[HPP_LANES-1:0];

   // RULE2 strap capture: taken once after reset, no configuration needed
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         mode_taken <= 1'b0;
         host_mode <= 1'b0;
         strap_width <= HPP_W8;
      end else if (clk_en && !mode_taken) begin
         mode_taken <= 1'b1;
         host_mode <= (mode_s[3:2] == HPP_MODE_HOST);
         strap_width <= mode_s[1:0];
      end
   end

   // RULE3 width select: straps rule until configuration is done
   assign width = config_done ? ctrl[HPP_CTRL_WIDTH_LSB +: 2] : strap_width;
   // RULE4 port kept after configuration only if instantiated or enabled
   assign avail = host_mode && (!config_done || port_inst || ctrl[HPP_CTRL_KEEP_BIT]);
   // RULE6 pad handover to user logic
   assign pads_user = !avail;

   // RULE1 lane mask from width
   always_comb begin
      case (width)
         HPP_W8: lanes = 4'h1;
         HPP_W16: lanes = 4'h3;
         default: lanes = 4'hf;
      endcase
   end

   // Lane bits and parity generation, one even bit per byte
   always_comb begin
      lane_bits = '0;
      par_gen = '0;
      for (int i = 0; i < HPP_LANES; i++) begin
         lane_bits[8*i +: 8] = {8{lanes[i]}};
         // RULE15 per-lane parity
         par_gen[i] = lanes[i] & ((^rd_data[8*i +: 8]) ^ HPP_PAR_ODD);
      end
   end

   // RULE5 parity check only when configuration enables it
   always_comb begin
      perr_now = 1'b0;
      for (int i = 0; i < HPP_LANES; i++) begin
         if (lanes[i] && (par_s[i] != ((^data_s[8*i +: 8]) ^ HPP_PAR_ODD))) begin
            perr_now = 1'b1;
         end
      end
      perr_now = perr_now && par_en_cfg;
   end

   // RULE13 new transaction seen on settled strobe while idle
   assign start = (state == HPP_IDLE) && strb_s && !strb_prev && avail;
   assign ack_done = (state == HPP_ACK);

   // Next state of the transaction engine
   always_comb begin
      next_state = state;
      case (state)
         HPP_IDLE: begin
            if (start) begin
               // RULE10 fabric region writes bypass the system bus
               next_state = (addr_s[HPP_AW-1 -: 2] == HPP_REGION_FAB && !rw_s) ?
                            HPP_FIFO : HPP_SBUS;
            end
         end
         HPP_SBUS: begin
            if (sb_ack) begin
               next_state = HPP_ACK;
            end
         end
         HPP_FIFO: begin
            if (fifo_in_ready) begin
               next_state = HPP_ACK;
            end
         end
         HPP_ACK: begin
            // RULE9 remaining burst beats go straight back out
            if (in_burst && beats_left != 2'h0) begin
               next_state = (cur_addr[HPP_AW-1 -: 2] == HPP_REGION_FAB && !cur_rd) ?
                            HPP_FIFO : HPP_SBUS;
            end else begin
               next_state = HPP_IDLE;
            end
         end
         default: next_state = HPP_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state <= HPP_IDLE;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   // Address, direction and burst tracking
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         cur_addr <= '0;
         cur_rd <= 1'b0;
         in_burst <= 1'b0;
         beats_left <= 2'h0;
      end else if (clk_en) begin
         if (start) begin
            // RULE13 address taken at the edge after the strobe
            cur_addr <= addr_s;
            cur_rd <= rw_s;
            in_burst <= burst_s;
            beats_left <= burst_s ? HPP_BURST_LAST : 2'h0;
         end else if (ack_done && in_burst && beats_left != 2'h0) begin
            // RULE8 next beat address advances with no idle cycle
            cur_addr <= cur_addr + 1'b1;
            beats_left <= beats_left - 1'b1;
         end
      end
   end

   // Write data held per beat, masked to active lanes
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         sb_wdata <= '0;
      end else if (clk_en && (start || ack_done)) begin
         sb_wdata <= data_s & lane_bits;
      end
   end

   // RULE12 system bus request mirrors the host transaction
   assign sb_req = (state == HPP_SBUS);
   assign sb_we = !cur_rd;
   assign sb_addr = cur_addr;
   // RULE11 configuration region flagged to the system bus
   assign sb_cfg = (cur_addr[HPP_AW-1 -: 2] == HPP_REGION_CFG);

   // Read data returned to the host
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         rd_data <= '0;
      end else if (clk_en && sb_req && sb_ack) begin
         rd_data <= sb_rdata & lane_bits;
      end
   end

   // Host side outputs; ta_n is one cycle per beat
   assign ta_n = !ack_done;
   assign hd_out = avail ? rd_data : user_d_out;
   assign hd_oe_n = avail ? !(ack_done && cur_rd) : user_d_oe_n;
   assign hp_out = par_gen;
   // Parity pins stay undriven when disabled
   assign hp_oe_n = !(avail && par_en_cfg && ack_done && cur_rd);

   // Fabric stream: back-pressure holds the transaction until space
   assign fifo_in_valid = (state == HPP_FIFO);
   hpp_fifo #(
      .W(HPP_DW),
      .D(HPP_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .clk_en(clk_en),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(sb_wdata),
      .out_valid(fab_valid),
      .out_ready(fab_ready),
      .out_data(fab_data)
   );

   // APB: zero wait states, unmapped offsets answer an error
   assign pready = 1'b1;
   assign apb_rd_ok = (paddr == HPP_REG_CTRL) || (paddr == HPP_REG_STAT) ||
                      (paddr == HPP_REG_COUNT);
   assign pslverr = psel && penable && !apb_rd_ok;
   assign apb_wr = psel && penable && pwrite;

   // Control register, software steers keep and width
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ctrl <= HPP_CTRL_RST;
      end else if (clk_en && apb_wr && paddr == HPP_REG_CTRL) begin
         ctrl <= pwdata[2:0];
      end
   end

   // Parity fault: set wins over a write-one clear
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         par_err <= 1'b0;
      end else if (clk_en) begin
         if ((start || ack_done) && !rw_s && perr_now) begin
            par_err <= 1'b1;
         end else if (apb_wr && paddr == HPP_REG_STAT && pwdata[HPP_STAT_PERR_BIT]) begin
            par_err <= 1'b0;
         end
      end
   end

   // Beat counter for monitoring
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         xfer_count <= '0;
      end else if (clk_en && ack_done) begin
         xfer_count <= xfer_count + 1'b1;
      end
   end

   // Read mux
   always_comb begin
      prdata = '0;
      case (paddr)
         HPP_REG_CTRL: prdata[2:0] = ctrl;
         HPP_REG_STAT: begin
            prdata[HPP_STAT_AVAIL_BIT] = avail;
            prdata[HPP_STAT_HOST_BIT] = host_mode;
            prdata[HPP_STAT_PERR_BIT] = par_err;
            prdata[HPP_STAT_WIDTH_LSB +: 2] = width;
            prdata[HPP_STAT_STATE_LSB +: 2] = state;
         end
         HPP_REG_COUNT: prdata[15:0] = xfer_count;
         default: prdata = '0;
      endcase
   end

   // Checks
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   width_lanes_a: assert property (width == HPP_W8 |-> lanes == 4'h1) // RULE1
      else $error("lane mask wrong for byte width");
   strap_hold_a: assert property (mode_taken |=> $stable(host_mode)) // RULE2
      else $error("strap changed after capture");
   strap_width_a: assert property (!config_done |-> width == strap_width) // RULE3
      else $error("width not from straps");
   keep_port_a: assert property (config_done && !port_inst && !ctrl[0] |-> !avail) // RULE4
      else $error("port kept without enable");
   parity_off_a: assert property (!par_en_cfg |-> hp_oe_n) // RULE5
      else $error("parity driven while disabled");
   pad_user_a: assert property (!avail |-> hd_oe_n == user_d_oe_n) // RULE6
      else $error("pads not handed to user");
   burst_step_a: assert property (ack_done && in_burst && beats_left != 2'h0 && clk_en
      |=> cur_addr == $past(cur_addr) + 1'b1 && !ack_done) // RULE9
      else $error("burst beat did not advance");
   bridge_ack_a: assert property (sb_req && sb_ack && clk_en |=> !ta_n) // RULE12
      else $error("system bus answer not acked");
   addr_take_a: assert property (start && clk_en |=> cur_addr == $past(addr_s)) // RULE13
      else $error("address not captured");
   fab_push_a: assert property (state == HPP_FIFO && fifo_in_ready && clk_en
      |=> ack_done) // RULE10
      else $error("fabric push not acked");
endmodule // hpp_port

/* File: testbench/hpp_host_model.sv */
/*
 * Host processor model that drives strobe, address and data, then waits for ta_n.
 * Assumes one shared clock, and a bench that calls xfer once at a time.
 */
`timescale 1ns/1ps

module hpp_host_model import hpp_pkg::*; (
   // Clock
   input wire logic clk_sys,
   // Host pins into the port
   output logic transaction_strobe_n,
   output logic host_rw,
   output logic burst_n,
   output logic [HPP_AW-1:0] host_address_bus,
   output logic [HPP_DW-1:0] hd_in,
   output logic [HPP_LANES-1:0] hp_in,
   // Answer from the port
   input wire logic ta_n,
   input wire logic [HPP_DW-1:0] hd_out,
   input wire logic [HPP_LANES-1:0] hp_out
);
   // Data and parity of each beat, cycles used by the last call
   logic [HPP_DW-1:0] got [4];
   logic [HPP_LANES-1:0] gotp [4];
   int waited;

   // even parity, one bit per byte lane
   function automatic logic [HPP_LANES-1:0] par_of(input logic [HPP_DW-1:0] d);
      for (int i = 0; i < HPP_LANES; i++) begin
         par_of[i] = ^d[8*i +: 8];
      end
   endfunction

   // Idle pins: strobe high
   initial begin
      transaction_strobe_n = 1'b1;
      host_rw = 1'b1;
      burst_n = 1'b1;
      host_address_bus = '0;
      hd_in = '0;
      hp_in = '0;
   end

   // strobe with 18-bit address, burst hint held
   task automatic xfer(input logic rd, input logic brst, input logic [HPP_AW-1:0] a,
         input logic [HPP_DW-1:0] wd, input logic bad, input int lim);
      int n;
      n = 0;
      waited = 0;
      @(posedge clk_sys);
      transaction_strobe_n <= 1'b0;
      host_rw <= rd;
      burst_n <= !brst;
      host_address_bus <= a;
      hd_in <= wd;
      hp_in <= par_of(wd) ^ HPP_LANES'(bad);
      // Bounded wait, one beat per ta_n pulse
      while (n < (brst ? 4 : 1) && waited < lim) begin
         @(posedge clk_sys);
         waited++;
         if (ta_n === 1'b0) begin
            got[n] = hd_out;
            gotp[n] = hp_out;
            n++;
         end
      end
      // Release at the answering edge; undriven lines must not look held
      transaction_strobe_n <= 1'b1;
      burst_n <= 1'b1;
      hd_in <= ~wd;
      hp_in <= ~hp_in;
      repeat (4) @(posedge clk_sys);
   endtask
endmodule // hpp_host_model

/* File: testbench/tb_host_processor_bus_port.sv */
/*
 * Self-checking bench for hpp_port: APB registers, host transfers and the fabric stream.
 * Assumes hpp_pkg and the host model are compiled first.
 */
`timescale 1ns/1ps

module tb_host_processor_bus_port import hpp_pkg::*; ;
   // Clock, straps and configuration status
   logic clk_sys = 1'b0;
   logic nrst, clk_en, config_done, port_inst, par_en_cfg, user_d_oe_n, pads_user;
   logic [3:0] cfg_mode;
   // Host pins, system bus, fabric and APB
   logic transaction_strobe_n, host_rw, burst_n, hd_oe_n, hp_oe_n, ta_n;
   logic [HPP_AW-1:0] host_address_bus, sb_addr;
   logic [HPP_DW-1:0] hd_in, hd_out, user_d_out, sb_wdata, sb_rdata, fab_data;
   logic [HPP_LANES-1:0] hp_in, hp_out;
   logic sb_req, sb_we, sb_cfg, sb_ack, fab_valid, fab_ready;
   logic psel, penable, pwrite, pready, pslverr, errq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdq, base, wr_dat, msk;
   logic [19:0] wr_log;
   logic [31:0] fq [$];
   int err_total = 0;
   int checks = 0;

   hpp_port dut_u (.clk_sys, .nrst, .clk_en, .cfg_mode, .config_done, .port_inst,
      .par_en_cfg, .transaction_strobe_n, .host_rw, .burst_n, .host_address_bus, .hd_in,
      .hd_out, .hd_oe_n, .hp_in, .hp_out, .hp_oe_n, .ta_n, .user_d_out, .user_d_oe_n,
      .pads_user, .sb_req, .sb_we, .sb_cfg, .sb_addr, .sb_wdata, .sb_rdata, .sb_ack,
      .fab_valid, .fab_ready, .fab_data, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr);
   hpp_host_model host_u (.clk_sys, .transaction_strobe_n, .host_rw, .burst_n,
      .host_address_bus, .hd_in, .hp_in, .ta_n, .hd_out, .hp_out);

   always #10 clk_sys = ~clk_sys;

   // Read pattern of the system bus, unique per address
   function automatic logic [31:0] pat(input logic [HPP_AW-1:0] a);
      return {14'h02a5, a};
   endfunction

   // System bus slave: ack one cycle late, so the port must wait
   always @(posedge clk_sys) begin
      sb_ack <= sb_req && !sb_ack;
      sb_rdata <= pat(sb_addr);
      if (sb_req && sb_ack) begin
         wr_log <= {sb_we, sb_cfg, sb_addr};
         wr_dat <= sb_wdata;
      end
   end

   // Fabric sink: words must leave in order
   always @(posedge clk_sys) begin
      if (fab_valid === 1'b1 && fab_ready === 1'b1) begin
         chk(fab_data, fq.pop_front());
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // APB transfer; pready waited for under a bound
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdq = prdata;
      errq = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         err_total++;
         report_and_stop();
      end
   endtask

   task automatic note(input string s);
      $display("Test %s done, mismatches %0d", s, err_total);
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      nrst = 1'b0;
      clk_en = 1'b1;
      cfg_mode = {HPP_MODE_HOST, HPP_W32};
      {config_done, port_inst, par_en_cfg, fab_ready} = 4'h0;
      user_d_out = 32'h1234_5678;
      user_d_oe_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      // Reset values, strap width, port usable before configuration
      apb(0, HPP_REG_CTRL, '0);
      chk(rdq, 32'h0000_0004);
      apb(0, HPP_REG_STAT, '0);
      chk(rdq & 32'h0000_0037, 32'h0000_0023);
      chk(32'(pads_user), 32'h0);
      chk(32'(hd_oe_n), 32'h1);
      chk(32'(hp_oe_n), 32'h1);
      apb(1, 8'h0c, 32'hffff_ffff);
      chk(32'(errq), 32'h1);
      apb(0, 8'h0c, '0);
      chk(rdq, 32'h0);
      note("registers");
      // Configuration and user writes reach the system bus
      host_u.xfer(0, 0, 18'h0_0010, 32'h1111_2222, 0, 40);
      chk(32'(wr_log), 32'h000c_0010);
      chk(wr_dat, 32'h1111_2222);
      host_u.xfer(0, 0, 18'h1_0234, 32'h3333_4444, 0, 40);
      chk(32'(wr_log), 32'h0009_0234);
      chk(wr_dat, 32'h3333_4444);
      host_u.xfer(1, 0, 18'h1_0567, '0, 0, 40);
      chk(32'(host_u.waited <= 6), 32'h1);
      chk(host_u.got[0], pat(18'h1_0567));
      chk(32'(host_u.gotp[0]), 32'(host_u.par_of(pat(18'h1_0567))));
      note("bridge");
      // Burst read of four beats, counted
      apb(0, HPP_REG_COUNT, '0);
      base = rdq;
      host_u.xfer(1, 1, 18'h1_0100, '0, 0, 80);
      for (int i = 0; i < 4; i++) begin
         chk(host_u.got[i], pat(18'h1_0100 + 18'(i)));
      end
      apb(0, HPP_REG_COUNT, '0);
      chk(rdq, base + 32'h0000_0004);
      note("burst");
      // Bad parity ignored when disabled, sticky and clearable when enabled
      host_u.xfer(0, 0, 18'h1_0020, 32'h0000_00ff, 1, 40);
      apb(0, HPP_REG_STAT, '0);
      chk(rdq & 32'h4, 32'h0);
      par_en_cfg <= 1'b1;
      host_u.xfer(0, 0, 18'h1_0020, 32'h0000_00ff, 1, 40);
      apb(0, HPP_REG_STAT, '0);
      chk(rdq & 32'h4, 32'h4);
      apb(1, HPP_REG_STAT, 32'h4);
      apb(0, HPP_REG_STAT, '0);
      chk(rdq & 32'h4, 32'h0);
      note("parity");
      // Fabric stream: fill sixteen, stall one more, then drain
      for (int i = 0; i < 17; i++) begin
         fq.push_back(32'hf000_0000 + 32'(i));
      end
      for (int i = 0; i < 16; i++) begin
         host_u.xfer(0, 0, 18'h2_0000 + 18'(i), fq[i], 0, 40);
         chk(32'(host_u.waited < 40), 32'h1);
      end
      fork
         host_u.xfer(0, 0, 18'h2_0010, fq[16], 0, 100);
         begin
            repeat (30) @(posedge clk_sys);
            fab_ready <= 1'b1;
         end
      join
      chk(32'(host_u.waited > 30), 32'h1);
      repeat (30) @(posedge clk_sys);
      chk(fq.size(), 0);
      note("fabric");
      // After configuration the control width selects the lanes
      config_done <= 1'b1;
      port_inst <= 1'b1;
      for (int w = 0; w < 3; w++) begin
         msk = (w == 0) ? 32'h0000_00ff : (w == 1) ? 32'h0000_ffff : 32'hffff_ffff;
         apb(1, HPP_REG_CTRL, 32'(2 * w));
         host_u.xfer(1, 0, 18'h1_0abc, '0, 0, 40);
         chk(host_u.got[0], pat(18'h1_0abc) & msk);
         chk(32'(host_u.gotp[0]), 32'(host_u.par_of(pat(18'h1_0abc) & msk)));
         apb(0, HPP_REG_STAT, '0);
         chk(rdq & 32'h30, 32'(w) << 4);
      end
      note("width");
      // Not kept after configuration: pads go to user logic
      port_inst <= 1'b0;
      apb(1, HPP_REG_CTRL, 32'h4);
      apb(0, HPP_REG_STAT, '0);
      chk(rdq & 32'h1, 32'h0);
      chk({31'h0, pads_user}, 32'h1);
      chk(hd_out, user_d_out);
      chk(32'(hd_oe_n), 32'(user_d_oe_n));
      host_u.xfer(1, 0, 18'h1_0567, '0, 0, 30);
      chk(host_u.waited, 30);
      apb(1, HPP_REG_CTRL, 32'h5);
      host_u.xfer(1, 0, 18'h1_0567, '0, 0, 30);
      chk(host_u.got[0], pat(18'h1_0567));
      note("keep");
      report_and_stop();
   end
endmodule // tb_host_processor_bus_port
